// File: fcl_params.svh
// Constants for the configuration loader
// How it works
// RQ1: Core held unready until memory fully loaded
// RQ2: Loader writes bitstream words into config memory
// RQ3: Active serial, passive serial and JTAG loading
// RQ4: Outside holds restart low minimum time
// RQ5: Restart rising edge starts active loading
// RQ6: Device drives flash chip select and data
// RQ7: Serial clock divided from internal clock
// RQ8: Command then address sent to flash
// RQ9: First command wakes flash from power-down
// RQ10: Wait at least 30 us after wake
// RQ11: Fast read from address zero onward
// RQ12: Flash returns data while clocked
// RQ13: Passive master supplies clock, select, data
// RQ14: JTAG port shifts bitstream when selected
// RQ15: Select held low until whole bitstream read
`ifndef FCL_PARAMS_SVH
`define FCL_PARAMS_SVH
`define FCL_CLK_MHZ 40
`define FCL_WAKE_US 30
`define FCL_WAKE_CYC ((`FCL_WAKE_US * `FCL_CLK_MHZ * 2 + 1) / 2)
`define FCL_SCK_HALF 4'h2
`define FCL_CMD_WAKE 8'hAB
`define FCL_CMD_FAST_READ 8'h0B
`define FCL_START_ADDR 24'h000000
`define FCL_DUMMY_BITS 6'h08
`define FCL_MEM_AW 10
`define FCL_MEM_WORDS 1024
`define FCL_MODE_ACTIVE 2'h0
`define FCL_MODE_PASSIVE 2'h1
`define FCL_MODE_JTAG 2'h2
`endif

// File: fcl_pkg.sv
// Types for the configuration loader
`default_nettype none
package fcl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAKE, ST_WAIT, ST_READ, ST_LOAD, ST_DONE
  } fcl_state_t;
  typedef struct packed {
    logic we;
    logic [9:0] addr;
    logic [7:0] data;
  } fcl_mem_wr_t;
endpackage : fcl_pkg
`default_nettype wire

// File: fcl_cfg_mem.sv
// Volatile configuration memory with registered read port
`default_nettype none
module fcl_cfg_mem
  import fcl_pkg::*;
(
  input wire logic mclk,
  input wire fcl_mem_wr_t wr,
  input wire logic [9:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:1023];

  // Write port and registered read
  always_ff @(posedge mclk) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data; // [RQ2]
    end
    rd_data <= mem[rd_addr];
  end
endmodule : fcl_cfg_mem
`default_nettype wire

// File: fcl_loader.sv
// Configuration loader: active flash, passive and JTAG modes
`include "fcl_params.svh"
`default_nettype none
module fcl_loader
  import fcl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic config_restart_low,
  input wire logic [1:0] mode_sel,
  input wire logic [`FCL_MEM_AW:0] stream_bytes,
  output logic flash_sck,
  output logic flash_cs_n,
  output logic flash_mosi,
  input wire logic flash_miso,
  input wire logic pas_sck,
  input wire logic pas_cs_n,
  input wire logic pas_data,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic user_mode,
  input wire logic [9:0] cfg_rd_addr,
  output logic [7:0] cfg_rd_data
);
  // Synchronisers: two flops for each restart, flash, passive and test port input
  logic [1:0] s1, s2, s3, s4, s5, s6, s7, s8;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 2'h0; s2 <= 2'h0; s3 <= 2'h0; s4 <= 2'h0;
      s5 <= 2'h0; s6 <= 2'h0; s7 <= 2'h0; s8 <= 2'h0;
    end else begin
      s1 <= {s1[0], config_restart_low};
      s2 <= {s2[0], flash_miso};
      s3 <= {s3[0], pas_sck};
      s4 <= {s4[0], pas_cs_n};
      s5 <= {s5[0], pas_data};
      s6 <= {s6[0], tck};
      s7 <= {s7[0], tms};
      s8 <= {s8[0], tdi};
    end
  end

  // Edge history after the second flop
  logic rst_d, psck_d, tck_d;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_d <= 1'h0;
      psck_d <= 1'h0;
      tck_d <= 1'h0;
    end else begin
      rst_d <= s1[1];
      psck_d <= s3[1];
      tck_d <= s6[1];
    end
  end
  wire logic restart_rise = s1[1] & ~rst_d; // [RQ5]
  wire logic psck_rise = s3[1] & ~psck_d;
  wire logic tck_rise = s6[1] & ~tck_d;
  wire logic restart_held = ~s1[1]; // [RQ4]

  fcl_state_t state, next_state;
  logic [1:0] mode;
  logic [3:0] div;
  logic [5:0] bit_cnt;
  logic [39:0] shreg;
  logic [7:0] rx;
  logic [2:0] rx_cnt;
  logic [`FCL_MEM_AW:0] byte_cnt;
  logic [15:0] wait_cnt;
  logic [2:0] jtag_st;
  fcl_mem_wr_t wr, next_wr;

  // Internal serial clock: rising edge and falling edge ticks
  wire logic div_end = (div == `FCL_SCK_HALF - 4'h1);
  wire logic sck_rise = div_end & ~flash_sck; // [RQ7]
  wire logic sck_fall = div_end & flash_sck;
  wire logic shifting = (state == ST_WAKE) || (state == ST_READ) || (state == ST_LOAD);
  wire logic all_loaded = (byte_cnt == stream_bytes);

  // Receive bit source per mode
  wire logic pas_take = psck_rise & ~s4[1]; // [RQ13]
  wire logic jtag_shift = tck_rise & (jtag_st == 3'h4); // [RQ14]
  wire logic act_take = sck_fall & (state == ST_LOAD) & (bit_cnt == 6'h00); // Sync lag [RQ12]
  wire logic take_bit = (mode == `FCL_MODE_ACTIVE) ? act_take :
                        (mode == `FCL_MODE_PASSIVE) ? pas_take : jtag_shift; // [RQ3]
  wire logic in_bit = (mode == `FCL_MODE_ACTIVE) ? s2[1] :
                      (mode == `FCL_MODE_PASSIVE) ? s5[1] : s8[1];
  wire logic byte_ready = take_bit & (rx_cnt == 3'h7) & (state == ST_LOAD);

  // Next state
  always_comb begin
    next_state = state;
    next_wr = '0;
    if (byte_ready) begin
      next_wr.we = 1'b1;
      next_wr.addr = byte_cnt[`FCL_MEM_AW-1:0];
      next_wr.data = {rx[6:0], in_bit}; // [RQ2]
    end
    case (state)
      ST_IDLE: if (restart_rise) begin
        next_state = (mode_sel == `FCL_MODE_ACTIVE) ? ST_WAKE : ST_LOAD; // [RQ5]
      end
      ST_WAKE: if (sck_fall && bit_cnt == 6'h01) begin
        next_state = ST_WAIT; // Last fall, no ninth edge
      end
      ST_WAIT: if (wait_cnt == 16'h0000) begin
        next_state = ST_READ; // [RQ10]
      end
      ST_READ: if (sck_fall && bit_cnt == 6'h01) begin
        next_state = ST_LOAD;
      end
      ST_LOAD: if (all_loaded) begin
        next_state = ST_DONE; // [RQ15]
      end
      default: next_state = state;
    endcase
    if (restart_held) begin
      next_state = ST_IDLE;
    end
  end

  // State, mode and memory write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      mode <= `FCL_MODE_ACTIVE;
      wr <= '0;
    end else begin
      state <= next_state;
      wr <= next_wr;
      if (state == ST_IDLE && restart_rise) begin
        mode <= mode_sel; // [RQ3]
      end
    end
  end

  // Serial clock divider, runs only while shifting
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 4'h0;
      flash_sck <= 1'b0;
    end else if (!shifting || mode != `FCL_MODE_ACTIVE || next_state != state) begin
      div <= 4'h0;
      flash_sck <= 1'b0;
    end else if (div_end) begin
      div <= 4'h0;
      flash_sck <= ~flash_sck; // [RQ7]
    end else begin
      div <= div + 4'h1;
    end
  end

  // Command shifter toward the flash
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= 40'h0;
      bit_cnt <= 6'h00;
      flash_mosi <= 1'b0;
      flash_cs_n <= 1'b1;
      wait_cnt <= 16'h0000;
    end else begin
      if (state == ST_IDLE && next_state == ST_WAKE) begin
        shreg <= {`FCL_CMD_WAKE, 32'h0}; // [RQ9]
        bit_cnt <= 6'h08;
        flash_cs_n <= 1'b0; // [RQ6]
        flash_mosi <= 1'(`FCL_CMD_WAKE >> 7);
      end else if (state == ST_WAKE && next_state == ST_WAIT) begin
        flash_cs_n <= 1'b1;
        wait_cnt <= 16'(`FCL_WAKE_CYC); // [RQ10]
      end else if (state == ST_WAIT && next_state == ST_READ) begin
        shreg <= {`FCL_CMD_FAST_READ, `FCL_START_ADDR, 8'h00}; // [RQ8] [RQ11]
        bit_cnt <= 6'h28;
        flash_cs_n <= 1'b0;
        flash_mosi <= 1'(`FCL_CMD_FAST_READ >> 7);
      end else if (next_state == ST_IDLE || next_state == ST_DONE) begin
        flash_cs_n <= 1'b1; // [RQ15]
        flash_mosi <= 1'b0;
      end else begin
        if (state == ST_WAIT) begin
          wait_cnt <= wait_cnt - 16'h1;
        end
        if (sck_fall && bit_cnt != 6'h00) begin
          shreg <= {shreg[38:0], 1'b0};
          flash_mosi <= shreg[38];
          bit_cnt <= bit_cnt - 6'h1; // [RQ12]
        end
      end
    end
  end

  // Byte assembly and load counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx <= 8'h00;
      rx_cnt <= 3'h0;
      byte_cnt <= '0;
    end else if (state == ST_IDLE) begin
      rx_cnt <= 3'h0;
      byte_cnt <= '0;
    end else if (take_bit && state == ST_LOAD) begin
      rx <= {rx[6:0], in_bit};
      rx_cnt <= rx_cnt + 3'h1;
      if (rx_cnt == 3'h7) begin
        byte_cnt <= byte_cnt + 11'h001;
      end
    end
  end

  // Minimal test port walker: reset, idle, select, capture, shift
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      jtag_st <= 3'h0;
      tdo <= 1'b0;
    end else if (tck_rise) begin
      case (jtag_st)
        3'h0: jtag_st <= s7[1] ? 3'h0 : 3'h1;
        3'h1: jtag_st <= s7[1] ? 3'h2 : 3'h1;
        3'h2: jtag_st <= s7[1] ? 3'h0 : 3'h3;
        3'h3: jtag_st <= s7[1] ? 3'h1 : 3'h4;
        default: jtag_st <= s7[1] ? 3'h1 : 3'h4; // [RQ14]
      endcase
      tdo <= rx[7];
    end
  end

  // Core released only when loading is complete
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      user_mode <= 1'b0;
    end else begin
      user_mode <= (state == ST_DONE); // [RQ1]
    end
  end

  fcl_cfg_mem u_mem (
    .mclk(mclk),
    .wr(wr),
    .rd_addr(cfg_rd_addr),
    .rd_data(cfg_rd_data)
  );
endmodule : fcl_loader
`default_nettype wire

// File: fcl_loader_asserts.sv
// Pin-level checks for the loader
`default_nettype none
module fcl_loader_asserts
  import fcl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic config_restart_low,
  input wire logic [1:0] mode_sel,
  input wire logic flash_sck,
  input wire logic flash_cs_n,
  input wire logic flash_mosi,
  input wire logic user_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic woke;
  logic [11:0] hi;
  // Wake seen, and run of select-high cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      woke <= 1'b0;
      hi <= 12'h000;
    end else begin
      woke <= config_restart_low & (woke | ~flash_cs_n);
      hi <= flash_cs_n ? hi + {11'h000, hi != 12'hFFF} : 12'h000;
    end
  end
  // High phase lasts two cycles unless a restart cuts the frame
  sequence s_high;
    (flash_sck || flash_cs_n) ##1 !flash_sck;
  endsequence
  property p_sck; $rose(flash_sck) |=> s_high; endproperty
  a_sck: assert property (p_sck)
    else $error("sck high phase wrong");
  property p_gap; $fell(flash_cs_n) && woke |-> hi >= 12'h4B0; endproperty
  a_gap: assert property (p_gap)
    else $error("wake gap too short");
  property p_go;
    $rose(config_restart_low) && mode_sel == 2'h0 |-> ##[2:8] !flash_cs_n;
  endproperty
  a_go: assert property (p_go)
    else $error("no select after start");
  property p_abort;
    $fell(config_restart_low) |-> ##[1:6] (flash_cs_n && !user_mode);
  endproperty
  a_abort: assert property (p_abort)
    else $error("restart low not obeyed");
  property p_hold; user_mode && config_restart_low |=> user_mode; endproperty
  a_hold: assert property (p_hold)
    else $error("ready dropped");
  property p_done; user_mode |-> flash_cs_n && !flash_sck; endproperty
  a_done: assert property (p_done)
    else $error("flash busy after load");
  property p_sel; flash_cs_n && $past(flash_cs_n) |-> !flash_sck; endproperty
  a_sel: assert property (p_sel)
    else $error("sck while deselected");
  property p_mosi; $rose(flash_sck) |=> $stable(flash_mosi) || flash_cs_n; endproperty
  a_mosi: assert property (p_mosi)
    else $error("mosi moved while sck high");
endmodule : fcl_loader_asserts
bind fcl_loader fcl_loader_asserts u_chk (.mclk(mclk), .rst_n(rst_n),
  .config_restart_low(config_restart_low), .mode_sel(mode_sel), .flash_sck(flash_sck),
  .flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi), .user_mode(user_mode));
`default_nettype wire

// File: fcl_flash_model.sv
// Serial flash stand-in answering the fast read
`default_nettype none
module fcl_flash_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [7:0] key,
  output logic miso
);
  int cnt = 0;
  logic [39:0] sr = '0;
  logic [39:0] hdr = '0;
  logic [7:0] wake_cmd = 8'h00;
  logic [7:0] b;
  initial miso = 1'b0;
  // Count bits per select window
  always @(negedge cs_n) cnt = 0;
  // Eight-bit window holds the wake byte
  always @(posedge cs_n) if (cnt == 8) wake_cmd = sr[7:0];
  // Shift in command and address
  always @(posedge sck) if (!cs_n) begin
    sr = {sr[38:0], mosi};
    cnt = cnt + 1;
    if (cnt == 40) hdr = sr;
  end
  // Byte n is key plus n times 8'h1D after 40 header clocks; released line toggles
  always @(negedge sck or posedge cs_n) begin
    b = key + 8'((cnt - 40) / 8) * 8'h1D;
    miso <= (!cs_n && cnt >= 40) ? b[7 - (cnt - 40) % 8] : ~miso;
  end
endmodule : fcl_flash_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the loader
`include "fcl_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, rst_cfg = 1'b0;
  logic [1:0] mode_sel = 2'h0;
  logic [10:0] nb = 11'h001;
  logic [7:0] key = 8'h00;
  logic [9:0] ra = 10'h000;
  logic [7:0] rd;
  logic sck, cs_n, mosi, miso, um, td;
  logic pas_sck = 1'b0, pas_cs_n = 1'b1, pas_data = 1'b0, tck = 1'b0, tms = 1'b0, tdi = 1'b0;
  int errors = 0, n_compared = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  fcl_loader dut (.mclk(mclk), .rst_n(rst_n), .config_restart_low(rst_cfg),
    .mode_sel(mode_sel), .stream_bytes(nb), .flash_sck(sck), .flash_cs_n(cs_n),
    .flash_mosi(mosi), .flash_miso(miso), .pas_sck(pas_sck), .pas_cs_n(pas_cs_n),
    .pas_data(pas_data), .tck(tck), .tms(tms), .tdi(tdi), .tdo(td), .user_mode(um),
    .cfg_rd_addr(ra), .cfg_rd_data(rd));
  fcl_flash_model flash (.sck(sck), .cs_n(cs_n), .mosi(mosi), .key(key), .miso(miso));
  task end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task clks(input int n);
    repeat (n) @(posedge mclk);
  endtask : clks
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  // Restart in a mode with a fresh random stream
  task start(input logic [1:0] m);
    rst_cfg <= 1'b0;
    mode_sel <= m;
    key <= 8'($urandom);
    nb <= 11'($urandom_range(16, 1));
    clks(8);
    rst_cfg <= 1'b1;
  endtask : start
  // One bit on passive or test port, 8 mclk link period
  task bit_out(input logic jt, input logic d);
    if (jt) tdi <= d;
    else pas_data <= d;
    clks(4);
    if (jt) tck <= 1'b1;
    else pas_sck <= 1'b1;
    clks(4);
    tck <= 1'b0;
    pas_sck <= 1'b0;
  endtask : bit_out
  // External master streams the bitstream
  task send(input logic jt);
    logic [7:0] v;
    logic [8:0] h;
    int n;
    h = '0;
    n = 0;
    pas_cs_n <= jt;
    for (int i = 0; i < 4 && jt; i++) begin
      tms <= (i == 1);
      bit_out(1'b1, 1'b0);
    end
    tms <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      v = key + 8'(i) * 8'h1D;
      for (int j = 7; j >= 0; j--) begin
        bit_out(jt, v[j]);
        h = {h[7:0], v[j]};
        n++;
        // Test port echoes the bit shifted eight clocks earlier
        if (jt && n > 8) chk(40'(td), 40'(h[8]));
      end
    end
    pas_cs_n <= 1'b1;
  endtask : send
  // Wait for ready, then read back every byte
  task check_mem;
    while (um !== 1'b1) clks(1);
    for (int i = 0; i < nb; i++) begin
      ra <= 10'(i);
      clks(2);
      chk(40'(rd), 40'(8'(key + 8'(i) * 8'h1D)));
    end
  endtask : check_mem
  // Main sequence
  initial begin
    void'($urandom(32'h597E5032));
    clks(6);
    rst_n <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      start(2'(k));
      if (k > 0) send(k == 2);
      check_mem();
      if (k > 0) chk(40'(cs_n), 40'h1);
      if (k == 0) chk(40'(flash.cnt), 40'(32 + `FCL_DUMMY_BITS + 8 * nb));
    end
    chk(40'(flash.wake_cmd), 40'(`FCL_CMD_WAKE));
    chk(flash.hdr, {`FCL_CMD_FAST_READ, `FCL_START_ADDR, 8'h00});
    start(`FCL_MODE_ACTIVE);
    // Past the wake window, then abort inside the first data byte
    clks(100);
    wait (flash.cnt > 44);
    rst_cfg <= 1'b0;
    clks(8);
    chk(40'({cs_n, um}), 40'h2);
    start(`FCL_MODE_ACTIVE);
    check_mem();
    chk(40'(flash.cnt), 40'(32 + `FCL_DUMMY_BITS + 8 * nb));
    end_sim();
  end
endmodule : testbench
`default_nettype wire
